// ### test/power_front.sv
/*
 Far-side model: supply comparator, settling PLL and bouncing push button.
 Assumes commands from the bench, changed after mclk edges.
*/
`default_nettype none
module power_front (
	// Commands
	input wire logic mclk, supply_cmd, press_cmd,
	// Pins
	output logic     supply_sense_input, pll_stable, push_button_input
);
	timeunit 1ns;
	timeprecision 1ps;
	int lock_cnt;
	int bounce;
	initial begin
		supply_sense_input = 1'b1;
		pll_stable = 1'b0;
		push_button_input = 1'b0;
		lock_cnt = 0;
		bounce = 0;
	end
	// PLL settles some time after supply returns; contacts chatter first
	always @(posedge mclk) begin
		supply_sense_input <= supply_cmd;
		lock_cnt <= supply_cmd ? lock_cnt + 1 : 0;
		pll_stable <= supply_cmd && lock_cnt > 40;
		bounce <= press_cmd ? bounce + 1 : 0;
		push_button_input <= press_cmd && (bounce > 6 || bounce[0]);
	end
endmodule
`default_nettype wire

// ### test/rfw_monitor.sv
/*
 Port checker for the reset, fault and wake sequencer.
 Assumes binding into the sequencer; one clock, mclk, and srst.
*/
`default_nettype none
module rfw_monitor (
	// Clock, reset and pins
	input wire logic       mclk, srst, reset_pin, supply_sense_input,
	input wire logic       battery_headroom_ok, push_button_input, pll_stable,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata, rdata,
	input wire logic       wr_stb, rd_stb,
	// Sequencer outputs
	input wire logic       cpu_reset, core_run_enable, watchdog_enable,
	input wire logic       pll_ok, mode_irq,
	input wire logic [3:0] mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_pin_reset: assert property (reset_pin [*5] |-> cpu_reset && mode == 4'h0)
		else $error("reset pin did not hold the core");
	a_reset_hold: assert property ($fell(reset_pin) |-> cpu_reset [*6])
		else $error("processor released too early");
	a_loss_clear: assert property ($fell(supply_sense_input) |-> ##[1:6] !pll_ok)
		else $error("lock flag kept after supply loss");
	a_full_lock: assert property ($rose(mode[0]) |-> pll_ok)
		else $error("full power without lock");
	a_sleep_stop: assert property ($rose(mode[3]) |-> ##[0:1] !core_run_enable)
		else $error("run enable high in sleep");
	a_wdog_full: assert property ($rose(watchdog_enable) |-> mode[0])
		else $error("watchdog raised outside full power");
	a_hold_batt: assert property ($rose(mode[2]) |-> $past(mode[1]))
		else $error("hold entered not from battery");
	a_loss_irq: assert property ($fell(mode[0]) && mode[1] |-> ##[0:2] mode_irq)
		else $error("no flag on lock loss");
	cover property ($rose(mode[2]));
	cover property ($rose(watchdog_enable));
	cover property ($fell(mode[3]) && mode[1]);
endmodule
bind reset_fault_wake_sequencer rfw_monitor rfw_monitor_i (.mclk(mclk), .srst(srst),
	.reset_pin(reset_pin), .supply_sense_input(supply_sense_input),
	.battery_headroom_ok(battery_headroom_ok), .push_button_input(push_button_input),
	.pll_stable(pll_stable), .addr(addr), .wdata(wdata), .rdata(rdata), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .cpu_reset(cpu_reset), .core_run_enable(core_run_enable),
	.watchdog_enable(watchdog_enable), .pll_ok(pll_ok), .mode_irq(mode_irq), .mode(mode));
`default_nettype wire

// ### test/testbench.sv
/*
 Self-checking bench for the sequencer with shortened crystal counts.
 Assumes a 50 MHz mclk and the far-side model power_front.
*/
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk, srst, reset_pin, hr_ok, supply_cmd, press_cmd;
	logic       sup, pll, btn, wr_stb, rd_stb, cpu_reset, run, wdog, pll_ok, irq;
	logic [3:0] addr, mode;
	logic [7:0] wdata, rdata, d;
	logic [15:0] seed;
	logic [2:0] p;
	int         n, e, num_errors, n_checks;
	reset_fault_wake_sequencer #(.XTAL_DIV(4),
		.LOCK_MAX(16), .DEB_CNT(4), .UNIT_SHORT(10), .UNIT_LONG(30))
		reset_fault_wake_sequencer_i (.mclk(mclk), .srst(srst), .reset_pin(reset_pin),
		.supply_sense_input(sup), .battery_headroom_ok(hr_ok), .push_button_input(btn),
		.pll_stable(pll), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .cpu_reset(cpu_reset), .core_run_enable(run),
		.watchdog_enable(wdog), .pll_ok(pll_ok), .mode(mode), .mode_irq(irq));
	power_front power_front_i (.mclk(mclk), .supply_cmd(supply_cmd), .press_cmd(press_cmd),
		.supply_sense_input(sup), .pll_stable(pll), .push_button_input(btn));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Wake delay in mclk cycles: period times unit ticks times 4
	function automatic int wake_cycles(input logic [2:0] prd, input logic u);
		return prd * (u ? 30 : 10) * 4;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_mode(input logic [3:0] m, input int lim);
		n = 0;
		while (mode !== m && n < lim) begin
			@(posedge mclk);
			n++;
		end
		`CHK(mode, m)
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#1000000;
		num_errors++;
		stop_test();
	end
	initial begin
		{srst, reset_pin, hr_ok, supply_cmd} = 4'hF;
		{press_cmd, wr_stb, rd_stb, addr, wdata} = '0;
		{num_errors, n_checks} = '0;
		seed = 16'h7581;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		repeat (6) @(posedge mclk);
		`CHK({cpu_reset, mode}, 5'h10)
		reset_pin <= 1'b0;
		wait_mode(4'h1, 17000);
		`CHK(n >= 16380, 1'b1)
		$display("power-up done");
		supply_cmd <= 1'b0;
		wait_mode(4'h2, 50);
		rd(4'h8);
		`CHK({pll_ok, d[2]}, 2'b01)
		`CHK(irq, 1'b1)
		wr(4'h0, 8'h08);
		wr(4'h8, 8'h0F);
		supply_cmd <= 1'b1;
		wait_mode(4'h1, 400);
		rd(4'h0);
		`CHK(d[3], 1'b1)
		rd(4'h8);
		`CHK({wdog, d[3]}, 2'b01)
		$display("battery round trip done");
		for (int u = 0; u < 2; u++) begin
			wr(4'h8, 8'h0F);
			supply_cmd <= 1'b0;
			wait_mode(4'h2, 50);
			seed = lfsr(seed);
			p = 3'(seed % 7) + 3'h1;
			wr(4'h0, {1'b0, p, u[0], 3'h4});
			repeat (14) @(posedge mclk);
			wr(4'h0, {1'b0, p, u[0], 3'h5});
			e = wake_cycles(p, u[0]);
			wait_mode(4'h8, 20);
			wait_mode(4'h2, 1000);
			`CHK(n inside {[e - 14 : e + 10]}, 1'b1)
			rd(4'h8);
			`CHK({run, d[1:0]}, 3'h6)
			rd(4'h4);
			`CHK(d[7], 1'b0)
			supply_cmd <= 1'b1;
			wait_mode(4'h1, 400);
		end
		$display("wake timer done");
		wr(4'h8, 8'h0F);
		supply_cmd <= 1'b0;
		wait_mode(4'h2, 50);
		wr(4'h0, 8'h02);
		wait_mode(4'h4, 20);
		press_cmd <= 1'b1;
		repeat (8) @(posedge mclk);
		press_cmd <= 1'b0;
		repeat (80) @(posedge mclk);
		`CHK(mode, 4'h4)
		press_cmd <= 1'b1;
		wait_mode(4'h2, 200);
		rd(4'h8);
		`CHK({run, d[0]}, 2'b11)
		press_cmd <= 1'b0;
		wr(4'h8, 8'h0F);
		wr(4'h0, 8'h09);
		wait_mode(4'h8, 20);
		supply_cmd <= 1'b1;
		wait_mode(4'h1, 400);
		rd(4'h0);
		`CHK({wdog, d}, 9'h100)
		$display("button and resume done");
		hr_ok <= 1'b0;
		supply_cmd <= 1'b0;
		wait_mode(4'h8, 50);
		hr_ok <= 1'b1;
		press_cmd <= 1'b1;
		repeat (100) @(posedge mclk);
		`CHK({run, mode}, 5'h08)
		press_cmd <= 1'b0;
		rd(4'hC);
		`CHK(d, 8'h00)
		reset_pin <= 1'b1;
		repeat (6) @(posedge mclk);
		`CHK(cpu_reset, 1'b1)
		reset_pin <= 1'b0;
		wait_mode(4'h2, 40);
		`CHK(n <= 24, 1'b1)
		$display("headroom and cold reset done");
		stop_test();
	end
endmodule
`default_nettype wire

// ### verilog/reset_fault_wake_sequencer.v
/*
 Reset, supply-fault and wake sequencer: reset timer, full-power and battery
 modes, display-hold and sleep, push-button and wake-timer wake-up.
 Assumes a 50 MHz mclk, pin inputs asynchronous to it, a synchronous reset,
 and a processor that reaches the registers over a plain strobe port.
*/
// How it works
// - Reset pin high stops everything and returns configuration to defaults.
// - After reset release with supply, processor held 4100 crystal cycles.
// - Without supply the reset timer lasts 2 crystal cycles, then battery-run.
// - Supply fall clears PLL lock and enters battery-run when battery present.
// - On supply return processor stays in reset until PLL lock, 2048-4096 cycles.
// - Supply fail with no battery headroom drops run enable and sleeps.
// - Battery-run to full power on lock keeps configuration and flags interrupt.
// - Hold or sleep to full power on lock resets configuration.
// - Watchdog enabled on entering full power from hold or sleep.
// - Supply return without battery enters full power with configuration reset.
// - Button rise or wake timer expiry wakes into battery-run.
// - Button rise in hold or sleep raises run enable and sets button flag.
// - Button debounced by a 32 Hz sampler rejecting short noise.
// - After an accepted edge, button ignored until software clears its flag.
// - Wake timer expiry raises run enable and sets timer flag.
// - Wake timer starts on hold or sleep entry; unit 1 minute or 2.5 s.
// - Three-bit period sets timer duration from 1 to 7 units.
// - Timer is reset whenever the processor is awake; disarmed on wake into battery-run.
// - Hold entered from battery-run only on software request; sleep also on headroom loss.
// - PLL loss flag on full to battery; gain flag on the reverse.
// - Sleep entered on headroom loss persists even if headroom recovers.
`include "rfw_defs.vh"
`default_nettype none

module reset_fault_wake_sequencer #(
	parameter XTAL_DIV   = `XTAL_DIV,
	parameter RESET_CNT  = `RESET_XTAL,
	parameter NOSUP_CNT  = `RESET_NOSUP_XTAL,
	parameter LOCK_MIN   = `LOCK_MIN_XTAL,
	parameter LOCK_MAX   = `LOCK_MAX_XTAL,
	parameter DEB_CNT    = `DEBOUNCE_XTAL,
	parameter UNIT_SHORT = `UNIT_SHORT_XTAL,
	parameter UNIT_LONG  = `UNIT_LONG_XTAL
) (
	// Clock and reset
	input  wire       mclk,
	input  wire       srst,
	// Pins
	input  wire       reset_pin,
	input  wire       supply_sense_input,
	input  wire       battery_headroom_ok,
	input  wire       push_button_input,
	input  wire       pll_stable,
	// Register port
	input  wire [3:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_stb,
	input  wire       rd_stb,
	output reg  [7:0] rdata,
	// Sequencer outputs
	output reg        cpu_reset,
	output reg        core_run_enable,
	output reg        watchdog_enable,
	output reg        pll_ok,
	output reg  [3:0] mode,
	output reg        mode_irq
);

	localparam [4:0] ST_RESET = 5'h01;
	localparam [4:0] ST_FULL  = 5'h02;
	localparam [4:0] ST_BATT  = 5'h04;
	localparam [4:0] ST_HOLD  = 5'h08;
	localparam [4:0] ST_SLEEP = 5'h10;

	// Pin synchronisers
	reg  [4:0] sync_a_r;
	reg  [4:0] sync_b_r;
	wire       rst_pin_s  = sync_b_r[0];
	wire       supply_s   = sync_b_r[1];
	wire       battery_headroom_ok_s   = sync_b_r[2];
	wire       button_s   = sync_b_r[3];
	wire       pll_st_s   = sync_b_r[4];

	always @(posedge mclk) begin
		if (srst) begin
			sync_a_r <= 5'h00;
			sync_b_r <= 5'h00;
		end else begin
			sync_a_r <= {pll_stable, push_button_input, battery_headroom_ok,
				supply_sense_input, reset_pin};
			sync_b_r <= sync_a_r;
		end
	end

	// Crystal tick from mclk
	reg  [15:0] div_r;
	reg         tick_r;
	always @(posedge mclk) begin
		if (srst) begin
			div_r  <= 16'h0000;
			tick_r <= 1'b0;
		end else if (div_r == XTAL_DIV[15:0] - 16'h0001) begin
			div_r  <= 16'h0000;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	reg  [4:0]  state_r;
	reg  [4:0]  state_nxt;
	reg  [12:0] rst_cnt_r;
	reg  [12:0] lock_cnt_r;
	reg         rst_done_r;
	reg  [7:0]  ctrl_r;
	reg  [3:0]  flags_r;
	reg         armed_r;
	reg         arm_unit_r;
	reg  [2:0]  arm_prd_r;
	reg  [20:0] unit_cnt_r;
	reg  [2:0]  prd_cnt_r;
	reg         timer_run_r;
	reg  [10:0] deb_cnt_r;
	reg  [1:0]  deb_hist_r;
	reg         headroom_lost_r;

	wire asleep     = state_r[3] | state_r[4];
	wire awake      = state_r[1] | state_r[2];
	wire sw_wr      = wr_stb & awake & ~cpu_reset;
	wire ctrl_wr    = sw_wr & (addr == `REG_CTRL);
	wire flags_wr   = sw_wr & (addr == `REG_FLAGS);
	wire sleep_req  = ctrl_wr & wdata[`CTRL_SLEEP];
	wire disp_req   = ctrl_wr & wdata[`CTRL_DISPLAY];
	wire deb_tick   = tick_r & (deb_cnt_r == DEB_CNT[10:0] - 11'h001);
	wire [20:0] unit_len = arm_unit_r ? UNIT_LONG[20:0] : UNIT_SHORT[20:0];
	// Accepted rise: low sample then two high samples at 32 Hz
	wire btn_edge   = deb_tick & button_s & (deb_hist_r == 2'b01)
		& ~flags_r[`FLG_BUTTON];
	wire tmr_expire = timer_run_r & tick_r & (unit_cnt_r == unit_len - 21'h000001)
		& (prd_cnt_r == arm_prd_r - 3'h1);
	wire btn_wake   = btn_edge & asleep & ~headroom_lost_r;
	wire tmr_wake   = tmr_expire & ~headroom_lost_r;
	wire lock_now   = supply_s & tick_r & ((lock_cnt_r >= LOCK_MIN[12:0] - 13'h0001
		& pll_st_s) | lock_cnt_r == LOCK_MAX[12:0] - 13'h0001);
	wire cfg_clear  = rst_pin_s | (asleep & state_nxt[1]);

	// Mode sequencing
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: begin
				if (!rst_pin_s && rst_done_r) begin
					if (!supply_s)
						state_nxt = ST_BATT;
					else if (pll_ok)
						state_nxt = ST_FULL;
				end
			end
			ST_FULL: begin
				if (!supply_s)
					state_nxt = battery_headroom_ok_s ? ST_BATT : ST_SLEEP;
			end
			ST_BATT: begin
				if (supply_s && pll_ok)
					state_nxt = ST_FULL;
				else if (!supply_s && !battery_headroom_ok_s)
					state_nxt = ST_SLEEP;
				else if (sleep_req)
					state_nxt = ST_SLEEP;
				else if (disp_req)
					state_nxt = ST_HOLD;
			end
			ST_HOLD, ST_SLEEP: begin
				if (supply_s && pll_ok)
					state_nxt = ST_FULL;
				else if (btn_wake || tmr_wake)
					state_nxt = ST_BATT;
				else if (state_r[3] && !battery_headroom_ok_s)
					state_nxt = ST_SLEEP;
			end
			default: state_nxt = ST_RESET;
		endcase
		if (rst_pin_s)
			state_nxt = ST_RESET;
	end

	always @(posedge mclk) begin
		if (srst)
			state_r <= ST_RESET;
		else
			state_r <= state_nxt;
	end

	// Reset timer and PLL lock tracking
	always @(posedge mclk) begin
		if (srst || rst_pin_s) begin
			rst_cnt_r  <= 13'h0000;
			rst_done_r <= 1'b0;
		end else if (state_r[0] && tick_r && !rst_done_r) begin
			if (rst_cnt_r >= (supply_s ? RESET_CNT[12:0] : NOSUP_CNT[12:0]) - 13'h0001)
				rst_done_r <= 1'b1;
			else
				rst_cnt_r <= rst_cnt_r + 13'h0001;
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			lock_cnt_r <= 13'h0000;
			pll_ok     <= 1'b0;
		end else if (!supply_s) begin
			lock_cnt_r <= 13'h0000;
			pll_ok     <= 1'b0;
		end else if (!pll_ok && tick_r) begin
			lock_cnt_r <= lock_cnt_r + 13'h0001;
			if (lock_now)
				pll_ok <= 1'b1;
		end
	end

	// Headroom loss latch
	always @(posedge mclk) begin
		if (srst || rst_pin_s || state_nxt[1])
			headroom_lost_r <= 1'b0;
		else if (!supply_s && !battery_headroom_ok_s && (state_r[1] || state_r[2] || state_r[3]))
			headroom_lost_r <= 1'b1;
	end

	// Push-button debounce at 32 Hz
	always @(posedge mclk) begin
		if (srst) begin
			deb_cnt_r  <= 11'h000;
			deb_hist_r <= 2'b11;
		end else if (tick_r) begin
			if (deb_tick) begin
				deb_cnt_r  <= 11'h000;
				deb_hist_r <= {deb_hist_r[0], button_s};
			end else begin
				deb_cnt_r <= deb_cnt_r + 11'h001;
			end
		end
	end

	// Control register and wake timer arming
	always @(posedge mclk) begin
		if (srst || cfg_clear) begin
			ctrl_r <= `CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_r <= {1'b0, wdata[`CTRL_PRD_HI:`CTRL_PRD_LO], wdata[`CTRL_UNIT],
				wdata[`CTRL_ARM], 2'b00};
		end
	end

	always @(posedge mclk) begin
		if (srst || rst_pin_s) begin
			armed_r    <= 1'b0;
			arm_unit_r <= 1'b0;
			arm_prd_r  <= 3'h0;
		end else if (asleep && state_nxt[2]) begin
			armed_r <= 1'b0;
		end else if (ctrl_wr && wdata[`CTRL_ARM]) begin
			armed_r    <= 1'b1;
			arm_unit_r <= wdata[`CTRL_UNIT];
			arm_prd_r  <= wdata[`CTRL_PRD_HI:`CTRL_PRD_LO];
		end
	end

	// Wake timer
	always @(posedge mclk) begin
		if (srst || !asleep) begin
			timer_run_r <= 1'b0;
			unit_cnt_r  <= 21'h000000;
			prd_cnt_r   <= 3'h0;
		end else if (!timer_run_r) begin
			timer_run_r <= armed_r && arm_prd_r != 3'h0 && unit_cnt_r == 21'h000000
				&& prd_cnt_r == 3'h0;
		end else if (tmr_expire) begin
			timer_run_r <= 1'b0;
		end else if (tick_r) begin
			if (unit_cnt_r == unit_len - 21'h000001) begin
				unit_cnt_r <= 21'h000000;
				prd_cnt_r  <= prd_cnt_r + 3'h1;
			end else begin
				unit_cnt_r <= unit_cnt_r + 21'h000001;
			end
		end
	end

	// Event flags: set wins over clear
	always @(posedge mclk) begin
		if (srst || rst_pin_s) begin
			flags_r <= 4'h0;
		end else begin
			flags_r <= (flags_wr ? flags_r & ~wdata[3:0] : flags_r)
				| {state_r[2] & state_nxt[1],
				state_r[1] & ~state_nxt[1] & supply_s == 1'b0,
				tmr_wake & asleep,
				btn_edge};
		end
	end

	// Outputs
	always @(posedge mclk) begin
		if (srst) begin
			cpu_reset       <= 1'b1;
			core_run_enable <= 1'b0;
			watchdog_enable <= 1'b0;
			mode            <= 4'h0;
			mode_irq        <= 1'b0;
		end else begin
			cpu_reset       <= ~(state_nxt[1] | (state_nxt[2]
				& ~(supply_s & ~pll_ok)));
			core_run_enable <= state_nxt[1] | state_nxt[2];
			if (rst_pin_s || !state_nxt[1])
				watchdog_enable <= 1'b0;
			else if (asleep && state_nxt[1])
				watchdog_enable <= 1'b1;
			mode     <= state_nxt[4:1];
			mode_irq <= |flags_r;
		end
	end

	// Register reads, data in the following cycle
	always @(posedge mclk) begin
		if (srst || !rd_stb) begin
			rdata <= 8'h00;
		end else begin
			case (addr)
				`REG_CTRL:   rdata <= ctrl_r;
				`REG_STATUS: rdata <= {armed_r, headroom_lost_r, pll_ok, 1'b0,
					state_r[4:1]};
				`REG_FLAGS:  rdata <= {4'h0, flags_r};
				default:     rdata <= 8'h00;
			endcase
		end
	end

endmodule

`default_nettype wire

// ### verilog/rfw_defs.vh
/*
 Constants for the reset, supply-fault and wake sequencer: clock rates,
 crystal-based timing counts, register offsets and field positions.
 Assumes inclusion by name from a design file under verilog/.
*/
`ifndef RFW_DEFS_VH
`define RFW_DEFS_VH

// Clock rates
`define MCLK_HZ          50000000
`define XTAL_HZ          32768
`define XTAL_DIV         (`MCLK_HZ / `XTAL_HZ)

// Timing in crystal cycles, with the rates and times they come from
`define RESET_XTAL       4100
`define RESET_NOSUP_XTAL 2
`define LOCK_MIN_XTAL    2048
`define LOCK_MAX_XTAL    4096
`define DEBOUNCE_HZ      32
`define DEBOUNCE_XTAL    (`XTAL_HZ / `DEBOUNCE_HZ)
`define UNIT_SHORT_MS    2500
`define UNIT_LONG_S      60
`define UNIT_SHORT_XTAL  (`XTAL_HZ * `UNIT_SHORT_MS / 1000)
`define UNIT_LONG_XTAL   (`XTAL_HZ * `UNIT_LONG_S)

// Register offsets
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_FLAGS        4'h8

// Control fields
`define CTRL_SLEEP       0
`define CTRL_DISPLAY     1
`define CTRL_ARM         2
`define CTRL_UNIT        3
`define CTRL_PRD_LO      4
`define CTRL_PRD_HI      6

// Flag fields
`define FLG_BUTTON       0
`define FLG_TIMER        1
`define FLG_PLL_LOSS     2
`define FLG_PLL_GAIN     3

// Reset values
`define CTRL_RESET       8'h00

`endif
